// ===== src/sbd_map.vh
// Purpose: Constants for the backlight dimming register bank
// Assumes: Included by every design file of the block
// Notes: Offsets are the command codes carried in the bus command byte
// What this block does
// - Bus modes read back last written brightness
// - Enhancement scaling never shows in brightness reads
// - Other modes read digitized brightness voltage
// - Digitized brightness excludes bottom offset
// - Brightness all ones gives maximum output
// - Brightness all zeros gives minimum output
// - Brightness resets to all ones
// - Ambient reading always returns raw sensor
// - Ambient reading ignores enhancement and limits
// - Writes to read-only registers change nothing
// - Command zero stores and returns brightness
// - Control register writable and readable
// - Low limit register writable and readable
// - High limit register writable and readable
// - Address 0x58 strap low, 0x5A high
// - Device is slave only, never initiates
// - Faults held in two-bit set/reset latch
// - Lamp status live, fault status latched until reset
// - ADC sample held during whole conversion
// - Limit registers clamp sensor dimming range
// - Mode chosen by control bits 3 to 1
// - Non-bus mode brightness writes leave output
// - Device never stretches the bus clock
// - Address strap sampled only at reset
`ifndef SBD_MAP_VH
`define SBD_MAP_VH

// ==========================================================
// Register command codes
`define SBD_REG_BRIGHT 8'h00
`define SBD_REG_CTRL 8'h01
`define SBD_REG_STAT 8'h02
`define SBD_REG_IDENT 8'h03
`define SBD_REG_AMB 8'h04
`define SBD_REG_AMB_LO 8'h05
`define SBD_REG_AMB_HI 8'h06

// ==========================================================
// Reset values
`define SBD_RST_BRIGHT 8'hFF
`define SBD_RST_CTRL 8'h00
`define SBD_RST_AMB_LO 8'h00
`define SBD_RST_AMB_HI 8'hFF

// ==========================================================
// Field layout
`define SBD_CTRL_MASK 8'h3F
`define SBD_MODE_LSB 1
`define SBD_MODE_MSB 3
`define SBD_ST_LAMP 3
`define SBD_ST_OVCUR 2
`define SBD_ST_OVTEMP 1
`define SBD_ST_ANY 0

// ==========================================================
// Dimming mode codes in control bits 3..1
`define SBD_MODE_BUS 3'h0
`define SBD_MODE_BUS_ENH 3'h1
`define SBD_MODE_PWM 3'h2
`define SBD_MODE_AMB 3'h3
`define SBD_MODE_AMB_ENH 3'h4

// ==========================================================
// Bus address, upper seven bits (0x58 / 0x5A as 8-bit)
`define SBD_ADDR_BASE 7'h2C
`define SBD_ADDR_STRAP_BIT 0

// ==========================================================
// Timing
`define SBD_CONV_CYCLES 8'h10

`endif

// ===== src/sbd_fault_latch.v
// Purpose: Two-bit set/reset latch for inverter faults
// Assumes: Fault inputs are already synchronised
// Notes: Cleared only by reset
`timescale 1ns/1ps
`default_nettype none
`include "sbd_map.vh"
module sbd_fault_latch (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_ovcur,
  input wire i_ovtemp,
  output reg [1:0] o_latched
);
  // ========================================================
  // Latch
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_latched <= 2'h0;
    end else begin
      o_latched <= o_latched | {i_ovcur, i_ovtemp};
    end
  end
endmodule
`default_nettype wire

// ===== src/sbd_adc_hold.v
// Purpose: Track and hold with conversion timer around the ADC
// Assumes: Sample to be converted arrives on i_sample
// Notes: Sample is frozen for the whole conversion window
`timescale 1ns/1ps
`default_nettype none
`include "sbd_map.vh"
module sbd_adc_hold #(
  parameter [7:0] CONV_CYCLES = `SBD_CONV_CYCLES
) (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire [7:0] i_sample,
  output reg [7:0] o_held,
  output reg [7:0] o_result
);
  reg [7:0] cnt_reg;
  // ========================================================
  // Hold and convert
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cnt_reg <= 8'h00;
      o_held <= 8'h00;
      o_result <= 8'h00;
    end else if (cnt_reg == 8'h00) begin
      o_held <= i_sample;
      cnt_reg <= CONV_CYCLES;
    end else begin
      cnt_reg <= cnt_reg - 8'h01;
      // Result published only at end, held value untouched meanwhile
      if (cnt_reg == 8'h01) begin
        o_result <= o_held;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/sbd_regs.v
// Purpose: Bus slave register bank of a backlight dimming controller
// Assumes: Bus lines and analog digitized values come from outside
// Notes: Read Byte and Write Byte only; no clock stretching
`timescale 1ns/1ps
`default_nettype none
`include "sbd_map.vh"
module sbd_regs #(
  parameter [7:0] ID_VALUE = 8'hA5, // Arbitrary identification value
  parameter [7:0] CONV_CYCLES = `SBD_CONV_CYCLES
) (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  output wire o_scl_oe,
  input wire i_address_strap_input,
  input wire [7:0] i_bright_volt,
  input wire [7:0] i_light_sensor_input,
  input wire i_lamp_on,
  input wire i_ovcur,
  input wire i_ovtemp,
  output reg [7:0] o_brightness_output,
  output reg [2:0] o_mode,
  output reg [7:0] o_amb_clamped,
  output reg o_enh_on
);
  // ========================================================
  // Input synchronisers
  reg [1:0] scl_s, sda_s, lamp_s, ovc_s, ovt_s, strap_s;
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      lamp_s <= 2'h0;
      ovc_s <= 2'h0;
      ovt_s <= 2'h0;
      strap_s <= 2'h0;
    end else begin
      scl_s <= {scl_s[0], i_scl};
      sda_s <= {sda_s[0], i_sda};
      lamp_s <= {lamp_s[0], i_lamp_on};
      ovc_s <= {ovc_s[0], i_ovcur};
      ovt_s <= {ovt_s[0], i_ovtemp};
      strap_s <= {strap_s[0], i_address_strap_input};
    end
  end

  // ========================================================
  // Address strap capture, once after reset release
  reg strap_done_reg;
  reg [1:0] strap_wait_reg;
  reg address_strap_bit_reg;
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      strap_done_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
      address_strap_bit_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
      // Wait for the synchroniser to fill before trusting the pin
      if (strap_wait_reg == 2'h2) begin
        address_strap_bit_reg <= strap_s[1];
        strap_done_reg <= 1'b1;
      end
    end
  end
  wire [6:0] my_addr = `SBD_ADDR_BASE |
    {6'h00, address_strap_bit_reg};

  // ========================================================
  // Line edge detection
  reg scl_d, sda_d;
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire start_cond = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire stop_cond = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // ========================================================
  // Registers and status
  reg [7:0] bright_reg, ctrl_reg, lo_reg, hi_reg;
  wire [1:0] flt_latched;
  wire [7:0] amb_held, amb_conv;

  sbd_fault_latch u_flt (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_ovcur(ovc_s[1]),
    .i_ovtemp(ovt_s[1]),
    .o_latched(flt_latched)
  );

  sbd_adc_hold #(.CONV_CYCLES(CONV_CYCLES)) u_adc (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_sample(i_light_sensor_input),
    .o_held(amb_held),
    .o_result(amb_conv)
  );

  wire [2:0] mode = ctrl_reg[`SBD_MODE_MSB:`SBD_MODE_LSB];
  wire bus_mode = (mode == `SBD_MODE_BUS) ||
    (mode == `SBD_MODE_BUS_ENH);

  // Lamp bit tracks live state every cycle; fault bits stay latched until reset
  wire [7:0] status_val = {4'h0, lamp_s[1], flt_latched[1],
    flt_latched[0], |flt_latched};

  function [7:0] sbd_read;
    input [7:0] code;
    begin
      case (code)
        // Bus modes return the stored byte, never scaled
        // Other modes return digitized voltage, offset-free
        `SBD_REG_BRIGHT: sbd_read = bus_mode ? bright_reg : i_bright_volt;
        `SBD_REG_CTRL: sbd_read = ctrl_reg;
        `SBD_REG_STAT: sbd_read = status_val;
        `SBD_REG_IDENT: sbd_read = ID_VALUE;
        `SBD_REG_AMB: sbd_read = amb_conv;
        `SBD_REG_AMB_LO: sbd_read = lo_reg;
        `SBD_REG_AMB_HI: sbd_read = hi_reg;
        default: sbd_read = 8'h00;
      endcase
    end
  endfunction

  // ========================================================
  // Slave protocol engine
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_ACK = 6'h04;
  localparam [5:0] ST_RX = 6'h08;
  localparam [5:0] ST_TX = 6'h10;
  localparam [5:0] ST_MACK = 6'h20;

  reg [5:0] state_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_reg;
  reg [1:0] phase_reg; // 0 command, 1 data
  reg [7:0] cmd_reg;
  reg sda_drv_reg;
  reg ack_pend_reg;
  reg rd_reg;
  reg wr_req_reg;
  reg [7:0] wr_data_reg;
  wire [7:0] rd_val = sbd_read(cmd_reg);

  // Only SDA is ever driven, and only low; SCL never held
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_drv_reg;
  assign o_scl_oe = 1'b0;

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      phase_reg <= 2'h0;
      cmd_reg <= 8'h00;
      sda_drv_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      rd_reg <= 1'b0;
      wr_req_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end else begin
      wr_req_reg <= 1'b0;
      if (start_cond) begin
        state_reg <= ST_ADDR;
        bit_reg <= 4'h0;
        sda_drv_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        sda_drv_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_drv_reg <= 1'b0;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s[1]};
              bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == my_addr) begin
                  sda_drv_reg <= 1'b1;
                  rd_reg <= shift_reg[0];
                  ack_pend_reg <= 1'b1;
                  state_reg <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                sda_drv_reg <= 1'b1;
                ack_pend_reg <= 1'b0;
                state_reg <= ST_ACK;
                if (phase_reg == 2'h0) begin
                  cmd_reg <= shift_reg;
                  phase_reg <= 2'h1;
                end else begin
                  wr_data_reg <= shift_reg;
                  wr_req_reg <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (ack_pend_reg && rd_reg) begin
                shift_reg <= rd_val;
                sda_drv_reg <= ~rd_val[7];
                bit_reg <= 4'h1;
                state_reg <= ST_TX;
              end else begin
                sda_drv_reg <= 1'b0;
                if (ack_pend_reg) begin
                  phase_reg <= 2'h0;
                end
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_reg == 4'h8) begin
                sda_drv_reg <= 1'b0;
                state_reg <= ST_MACK;
              end else begin
                sda_drv_reg <= ~shift_reg[3'h7 - bit_reg[2:0]];
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          ST_MACK: begin
            // Single byte only; master NACK then stop
            sda_drv_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ========================================================
  // Register writes
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      bright_reg <= `SBD_RST_BRIGHT;
      ctrl_reg <= `SBD_RST_CTRL;
      lo_reg <= `SBD_RST_AMB_LO;
      hi_reg <= `SBD_RST_AMB_HI;
    end else if (wr_req_reg) begin
      case (cmd_reg)
        `SBD_REG_BRIGHT: bright_reg <= wr_data_reg;
        `SBD_REG_CTRL: ctrl_reg <= wr_data_reg & `SBD_CTRL_MASK;
        `SBD_REG_AMB_LO: lo_reg <= wr_data_reg;
        `SBD_REG_AMB_HI: hi_reg <= wr_data_reg;
        // Status, identity, ambient reading ignore writes
        default: bright_reg <= bright_reg;
      endcase
    end
  end

  // ========================================================
  // Dimming outputs
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_brightness_output <= `SBD_RST_BRIGHT;
      o_mode <= `SBD_MODE_BUS;
      o_amb_clamped <= 8'h00;
      o_enh_on <= 1'b0;
    end else begin
      o_mode <= mode;
      o_enh_on <= (mode == `SBD_MODE_BUS_ENH) ||
        (mode == `SBD_MODE_AMB_ENH);
      // Code maps straight to level: FF max, 00 min
      if (bus_mode) begin
        o_brightness_output <= bright_reg;
      end
      if (amb_held < lo_reg) begin
        o_amb_clamped <= lo_reg;
      end else if (amb_held > hi_reg) begin
        o_amb_clamped <= hi_reg;
      end else begin
        o_amb_clamped <= amb_held;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/sbd_regs_monitor.sv
// Purpose: Port checker for the dimming register bank
// Assumes: Bound to sbd_regs, one clock domain
// Notes: Register contents are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module sbd_regs_monitor (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_scl_oe,
  input wire logic [7:0] o_brightness_output,
  input wire logic [2:0] o_mode,
  input wire logic [7:0] o_amb_clamped,
  input wire logic o_enh_on
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic [7:0] oe_run;
  // ==========================================
  // Length of one drive run on the data line
  always @(posedge i_ref_clk) begin
    if (!i_nrst || !o_sda_oe)
      oe_run <= 8'h00;
    else if (oe_run != 8'hFF)
      oe_run <= oe_run + 8'h01;
  end
  // ==========================================
  // Assertions
  no_stretch_a:
    assert property (!o_scl_oe) else $error("clock line pulled");
  sda_low_a:
    assert property (o_sda_oe |-> !o_sda) else $error("data driven high");
  reset_vals_a:
    assert property ($rose(i_nrst) |-> o_brightness_output == 8'hFF &&
      o_mode == 3'h0 && !o_sda_oe && o_amb_clamped == 8'h00)
      else $error("bad value after reset");
  enh_mode_a:
    assert property (o_enh_on == (o_mode == 3'h1 || o_mode == 3'h4))
      else $error("enhancement flag wrong");
  oe_edge_a:
    assert property ($changed(o_sda_oe) |-> !$past(i_scl))
      else $error("data drive changed with clock high");
  oe_bounded_a:
    assert property (oe_run <= 8'd90) else $error("data held too long");
  bright_ack_a:
    assert property ($changed(o_brightness_output) && o_mode <= 3'h1 |->
      o_sda_oe || $past(o_sda_oe)) else $error("level moved off a write");
  mode_ack_a:
    assert property ($changed(o_mode) |-> o_sda_oe)
      else $error("mode moved off a write");
  cover property ($rose(o_sda_oe));
  cover property (o_mode == 3'h2);
  cover property ($changed(o_brightness_output));
endmodule
bind sbd_regs sbd_regs_monitor sbd_regs_monitor_inst (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_scl(i_scl), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .o_scl_oe(o_scl_oe),
  .o_brightness_output(o_brightness_output), .o_mode(o_mode),
  .o_amb_clamped(o_amb_clamped), .o_enh_on(o_enh_on));
`default_nettype wire

// ===== tb/sbd_host.sv
// Purpose: Bus master model issuing Read Byte and Write Byte
// Assumes: Open-drain lines resolved by the bench
// Notes: Clock idles high between frames; 200 ns bit period
`timescale 1ns/1ps
`default_nettype none
module sbd_host (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic q;
    repeat (2) @(negedge i_ref_clk);
  endtask
  // Works as start and repeated start alike
  task automatic start;
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic stop;
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
  endtask
  // Sampled mid-high so a late device answer is still seen
  task automatic bitx(input logic b, output logic r);
    o_sda_low = !b;
    q();
    o_scl = 1'b1;
    q();
    r = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic bytex(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
  endtask
  task automatic write_byte(input logic [7:0] a, c, d, output logic ok);
    logic [7:0] x;
    logic k0, k1, k2;
    start();
    bytex(a, x);
    bitx(1'b1, k0);
    bytex(c, x);
    bitx(1'b1, k1);
    bytex(d, x);
    bitx(1'b1, k2);
    stop();
    ok = !k0 && !k1 && !k2;
  endtask
  task automatic read_byte(input logic [7:0] a, c, output logic [7:0] d,
                           output logic ok);
    logic [7:0] x;
    logic k0, k1, k2, n;
    start();
    bytex(a, x);
    bitx(1'b1, k0);
    bytex(c, x);
    bitx(1'b1, k1);
    start();
    bytex(a | 8'h01, x);
    bitx(1'b1, k2);
    bytex(8'hFF, d);
    bitx(1'b1, n);
    stop();
    ok = !k0 && !k1 && !k2;
  endtask
endmodule
`default_nettype wire

// ===== tb/sbd_regs_tb.sv
// Purpose: Self-checking bench for the dimming register bank
// Assumes: Host model drives the bus; bench drives analog values
// Notes: Inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module sbd_regs_tb;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary identification value
  logic clk, nrst, scl, host_low, strap, lamp, ovcur, ovtemp, ok;
  logic sda_o, sda_oe, scl_oe, enh;
  logic [7:0] bvolt, sens, bright, amb, adr, d;
  logic [2:0] mode;
  wire sda_line;
  int n_mismatch, checks_done;
  // Pull-up: line low only while someone pulls
  assign sda_line = !(host_low || (sda_oe && !sda_o));
  sbd_regs #(.ID_VALUE(ID), .CONV_CYCLES(8'h10)) sbd_regs_inst (
    .i_ref_clk(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda_line),
    .o_sda(sda_o), .o_sda_oe(sda_oe), .o_scl_oe(scl_oe),
    .i_address_strap_input(strap), .i_bright_volt(bvolt),
    .i_light_sensor_input(sens), .i_lamp_on(lamp), .i_ovcur(ovcur),
    .i_ovtemp(ovtemp), .o_brightness_output(bright), .o_mode(mode),
    .o_amb_clamped(amb), .o_enh_on(enh));
  sbd_host sbd_host_inst (.i_ref_clk(clk), .i_sda(sda_line), .o_scl(scl),
    .o_sda_low(host_low));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, v);
    sbd_host_inst.write_byte(adr, c, v, ok);
    chk({7'h0, ok}, 8'h01, "write ack");
  endtask
  task automatic rdchk(input logic [7:0] c, exp);
    sbd_host_inst.read_byte(adr, c, d, ok);
    chk({7'h0, ok}, 8'h01, "read ack");
    chk(d, exp, "read data");
  endtask
  task automatic do_reset;
    @(negedge clk) nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    rdchk(8'h00, 8'hFF);
    chk(bright, 8'hFF, "level at reset");
    rdchk(8'h01, 8'h00);
    rdchk(8'h05, 8'h00);
    rdchk(8'h06, 8'hFF);
  endtask
  task automatic t_bus;
    wr(8'h00, 8'h00);
    rdchk(8'h00, 8'h00);
    chk(bright, 8'h00, "minimum level");
    wr(8'h01, 8'h02);
    chk({4'h0, enh, mode}, 8'h09, "enhanced bus mode");
    wr(8'h00, 8'h9A);
    rdchk(8'h00, 8'h9A);
    wr(8'h01, 8'hC1);
    rdchk(8'h01, 8'h01);
    chk({5'h0, mode}, 8'h00, "plain bus mode");
    wr(8'h00, 8'hFF);
    chk(bright, 8'hFF, "maximum level");
  endtask
  task automatic t_nonbus;
    logic [7:0] b0;
    @(negedge clk) bvolt = 8'h77;
    for (int m = 2; m <= 4; m++) begin
      wr(8'h01, 8'(m << 1));
      chk({5'h0, mode}, 8'(m), "mode select");
      b0 = bright;
      wr(8'h00, 8'h11);
      chk(bright, b0, "level kept off bus mode");
      rdchk(8'h00, 8'h77);
    end
    wr(8'h01, 8'h00);
  endtask
  task automatic t_amb;
    wr(8'h05, 8'h20);
    wr(8'h06, 8'hC0);
    rdchk(8'h05, 8'h20);
    rdchk(8'h06, 8'hC0);
    @(negedge clk) sens = 8'h10;
    repeat (40) @(negedge clk);
    rdchk(8'h04, 8'h10);
    chk(amb, 8'h20, "clamp low");
    sens = 8'hF0;
    repeat (40) @(negedge clk);
    rdchk(8'h04, 8'hF0);
    chk(amb, 8'hC0, "clamp high");
  endtask
  task automatic t_ro;
    for (int c = 2; c <= 4; c++) wr(8'(c), 8'h55);
    rdchk(8'h02, 8'h08);
    rdchk(8'h03, ID);
    rdchk(8'h04, 8'hF0);
    wr(8'h07, 8'hAA);
    rdchk(8'h07, 8'h00);
    rdchk(8'h05, 8'h20);
  endtask
  task automatic t_fault;
    @(negedge clk) ovtemp = 1'b1;
    lamp = 1'b0;
    repeat (10) @(negedge clk);
    ovtemp = 1'b0;
    repeat (10) @(negedge clk);
    rdchk(8'h02, 8'h03);
    ovcur = 1'b1;
    lamp = 1'b1;
    repeat (10) @(negedge clk);
    ovcur = 1'b0;
    rdchk(8'h02, 8'h0F);
  endtask
  task automatic t_addr;
    sbd_host_inst.write_byte(8'h5A, 8'h00, 8'h33, ok);
    chk({7'h0, ok}, 8'h00, "other address ignored");
    @(negedge clk) strap = 1'b1;
    // Byte stored while a non-bus mode was active is still held
    rdchk(8'h00, 8'h11);
    do_reset();
    adr = 8'h5A;
    rdchk(8'h00, 8'hFF);
    sbd_host_inst.read_byte(8'h58, 8'h00, d, ok);
    chk({7'h0, ok}, 8'h00, "old address ignored");
  endtask
  initial begin
    nrst = 1'b0;
    strap = 1'b0;
    lamp = 1'b1;
    ovcur = 1'b0;
    ovtemp = 1'b0;
    bvolt = 8'h00;
    sens = 8'h00;
    adr = 8'h58;
    n_mismatch = 0;
    checks_done = 0;
    do_reset();
    t_reset();
    t_bus();
    t_nonbus();
    t_amb();
    t_ro();
    t_fault();
    t_addr();
    end_sim();
  end
  // Run needs well under a millisecond of bus traffic
  initial begin
    #2_000_000;
    n_mismatch++;
    $display("wrong value at %0t: run timed out", $time);
    end_sim();
  end
endmodule
`default_nettype wire
